// ### pkg/kbl_link_if.sv
// Interface for the keyboard link: clock and data lines, open-collector.
// Each end gives drive enables; the wire level is low if any end pulls low.
`timescale 1ns/100ps
interface kbl_link_if;
  logic kbd_clock_line_oe;
  logic kbd_data_line_kbd_oe;
  logic kbd_data_line_host_oe;
  logic kbd_clock_line;
  logic kbd_data_line;

  // Pull-ups at both ends; any enable pulls low
  assign kbd_clock_line = ~kbd_clock_line_oe;
  assign kbd_data_line = ~(kbd_data_line_kbd_oe | kbd_data_line_host_oe);

  modport kbd (
    output kbd_clock_line_oe,
    output kbd_data_line_kbd_oe,
    input kbd_clock_line,
    input kbd_data_line
  );

  modport host (
    output kbd_data_line_host_oe,
    input kbd_clock_line,
    input kbd_data_line
  );
endinterface : kbl_link_if

// ### pkg/kbl_pkg.sv
// Package for the two-line keyboard serial link: timing, codes, state enums.
// Assumes a single 125 MHz clock at both ends.
package kbl_pkg;
  localparam int CLK_MHZ = 125;
  // Bit phase times in microseconds
  localparam int SETUP_US = 20;
  localparam int LOW_US = 20;
  localparam int HOLD_US = 20;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int LOW_CYC = LOW_US * CLK_MHZ;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  // Acknowledge: least detected width and host pulse width
  localparam int ACK_MIN_US = 1;
  localparam int ACK_MIN_CYC = ACK_MIN_US * CLK_MHZ;
  localparam int ACK_PULSE_US = 85;
  localparam int ACK_PULSE_CYC = ACK_PULSE_US * CLK_MHZ;
  // Acknowledge timeout
  localparam int ACK_TMO_MS = 143;
  localparam int ACK_TMO_CYC = ACK_TMO_MS * 1000 * CLK_MHZ;
  localparam int BITS_PER_WORD = 8;
  localparam logic [7:0] CODE_LOST_SYNC = 8'hF9;
  localparam logic [7:0] CODE_STREAM_START = 8'hFD;
  localparam logic [7:0] CODE_STREAM_END = 8'hFE;
  localparam logic [6:0] CODE_CAPS_LOCK = 7'h62;
  localparam logic [3:0] RESET_BITCNT = 4'h0;

  typedef enum logic [2:0] {
    KBL_IDLE, KBL_SETUP, KBL_LOW, KBL_HOLD, KBL_WAIT_ACK
  } kbl_kstate_t;

  typedef enum logic [1:0] {
    KBL_SYNC_POWERUP, KBL_SYNC_LOST, KBL_SYNC_OK
  } kbl_sync_t;

  typedef enum logic [1:0] {
    KBL_BOOT_START, KBL_BOOT_KEYS, KBL_BOOT_END, KBL_BOOT_DONE
  } kbl_boot_t;

  // Rotate left by one: order on the wire becomes 6..0 then 7
  function automatic logic [7:0] kbl_rotl(input logic [7:0] v);
    return {v[6:0], v[7]};
  endfunction : kbl_rotl

  // Undo the rotation at the receiver
  function automatic logic [7:0] kbl_rotr(input logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction : kbl_rotr
endpackage : kbl_pkg

// ### rtl/kbl_host.sv
// Host end of the serial link: receives words and sends the ack pulse.
// Assumes the keyboard drives the clock line; both lines are sampled here.
`timescale 1ns/100ps
module kbl_host (
  input wire logic clk_i,
  input wire logic rst_i,
  kbl_link_if.host link,
  output logic [7:0] code_o,
  output logic code_valid_o
);
  typedef struct packed {
    logic c1;
    logic c2;
    logic c3;
    logic d1;
    logic d2;
    logic [7:0] shift;
    logic [3:0] bitn;
    logic [15:0] ack_cnt;
    logic ack_oe;
    logic [7:0] code;
    logic valid;
  } kbl_host_state_t;

  kbl_host_state_t h_reg;
  kbl_host_state_t h_next;

  assign link.kbd_data_line_host_oe = h_reg.ack_oe;
  assign code_o = h_reg.code;
  assign code_valid_o = h_reg.valid;

  // Sample on keyboard clock rising edge, then ack for 85us
  always_comb begin
    h_next = h_reg;
    h_next.c1 = link.kbd_clock_line;
    h_next.c2 = h_reg.c1;
    h_next.c3 = h_reg.c2;
    h_next.d1 = link.kbd_data_line;
    h_next.d2 = h_reg.d1;
    h_next.valid = 1'b0;
    if (h_reg.c2 && !h_reg.c3 && !h_reg.ack_oe) begin
      h_next.shift = {h_reg.shift[6:0], ~h_reg.d2}; // Invert the line
      h_next.bitn = h_reg.bitn + 4'h1;
      if (h_reg.bitn == 4'h7) begin
        h_next.bitn = 4'h0;
        h_next.code = kbl_pkg::kbl_rotr({h_reg.shift[6:0], ~h_reg.d2});
        h_next.valid = 1'b1;
        h_next.ack_oe = 1'b1;
        h_next.ack_cnt = 16'h0;
      end
    end
    if (h_reg.ack_oe) begin
      h_next.ack_cnt = h_reg.ack_cnt + 16'h1;
      if (h_reg.ack_cnt == 16'(kbl_pkg::ACK_PULSE_CYC - 1)) begin
        h_next.ack_oe = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_reg <= '0;
      h_reg.c1 <= 1'b1;
      h_reg.c2 <= 1'b1;
      h_reg.c3 <= 1'b1;
      h_reg.d1 <= 1'b1;
      h_reg.d2 <= 1'b1;
    end else begin
      h_reg <= h_next;
    end
  end
endmodule : kbl_host

// ### rtl/kbl_keyboard.sv
// Keyboard end of the serial link: shifts key codes out, waits for ack.
// A missed host ack times out into resync; link lines come via kbl_link_if.
// Contract
// - Keyboard drives clock; data shared, open-collector
// - Both lines released high when idle
// - Place bit, then pulse clock low/high
// - Release data after last clock pulse
// - Host acks with low pulse >=1us
// - Keyboard detects ack pulses of 1us
// - Host ack pulse lasts 85us
// - Rotate left; order 6..0 then 7
// - Data line inverted: low means one
// - 20us setup, 20us low, 20us hold
// - Seven-bit code plus up/down flag
// - Caps lock sends only on press
// - 143ms ack timeout enters resync ones
// - After resync send F9, then resend
// - Power-up: resync, FD, held keys, FE
`timescale 1ns/100ps
module kbl_keyboard #(
  parameter int TMO_CYC = kbl_pkg::ACK_TMO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  kbl_link_if.kbd link,
  input wire logic key_valid_i,
  input wire logic [6:0] key_code_i,
  input wire logic key_up_i,
  input wire logic caps_led_on_i,
  input wire logic held_valid_i,
  input wire logic [6:0] held_code_i,
  input wire logic held_last_i,
  output logic key_ready_o,
  output logic held_ready_o,
  output logic synced_o
);
  typedef struct packed {
    kbl_pkg::kbl_kstate_t st;
    kbl_pkg::kbl_sync_t sync;
    kbl_pkg::kbl_boot_t boot;
    logic [31:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] word;
    logic resync;
    logic resend;
    logic clk_oe;
    logic dat_oe;
    logic d1;
    logic d2;
    logic [15:0] low_cnt;
    logic ack;
    logic held_done;
  } kbl_kbd_state_t;

  kbl_kbd_state_t s_reg;
  kbl_kbd_state_t s_next;

  // Drive lines from flops only
  assign link.kbd_clock_line_oe = s_reg.clk_oe;
  assign link.kbd_data_line_kbd_oe = s_reg.dat_oe;
  assign synced_o = s_reg.sync == kbl_pkg::KBL_SYNC_OK;
  assign key_ready_o = s_reg.st == kbl_pkg::KBL_IDLE && synced_o && s_reg.boot == kbl_pkg::KBL_BOOT_DONE
    && !s_reg.resend;
  assign held_ready_o = s_reg.st == kbl_pkg::KBL_IDLE && synced_o && s_reg.boot == kbl_pkg::KBL_BOOT_KEYS
    && !s_reg.resend;

  // Next-state logic for the whole keyboard end
  always_comb begin
    logic [7:0] code;
    logic load;
    code = 8'h00;
    load = 1'b0;
    s_next = s_reg;
    // Two-flop sync of the shared data line, then width filter
    s_next.d1 = link.kbd_data_line;
    s_next.d2 = s_reg.d1;
    if (!s_reg.d2 && !s_reg.dat_oe) begin
      if (s_reg.low_cnt != 16'hFFFF) begin
        s_next.low_cnt = s_reg.low_cnt + 16'h0001;
      end
    end else begin
      s_next.low_cnt = 16'h0000;
    end
    // Latch any ack of at least the minimum width; sync delay covers the tail
    if (s_reg.low_cnt >= 16'(kbl_pkg::ACK_MIN_CYC - 2) && s_reg.st == kbl_pkg::KBL_WAIT_ACK) begin
      s_next.ack = 1'b1;
    end
    case (s_reg.st)
      kbl_pkg::KBL_IDLE: begin
        s_next.clk_oe = 1'b0;
        s_next.dat_oe = 1'b0;
        if (s_reg.sync != kbl_pkg::KBL_SYNC_OK) begin
          code = 8'hFF; // Single one bit per resync attempt
          s_next.resync = 1'b1;
          s_next.bitn = 4'h7;
          load = 1'b1;
        end else if (s_reg.resend) begin
          code = s_reg.word;
          s_next.resend = 1'b0;
          load = 1'b1;
        end else if (s_reg.boot == kbl_pkg::KBL_BOOT_START) begin
          code = kbl_pkg::CODE_STREAM_START;
          s_next.boot = kbl_pkg::KBL_BOOT_KEYS;
          load = 1'b1;
        end else if (s_reg.boot == kbl_pkg::KBL_BOOT_KEYS) begin
          if (s_reg.held_done) begin
            s_next.boot = kbl_pkg::KBL_BOOT_END;
          end else if (held_valid_i) begin
            code = {1'b0, held_code_i}; // Held keys reported as pressed
            s_next.held_done = held_last_i;
            load = 1'b1;
          end else begin
            s_next.boot = kbl_pkg::KBL_BOOT_END;
          end
        end else if (s_reg.boot == kbl_pkg::KBL_BOOT_END) begin
          code = kbl_pkg::CODE_STREAM_END;
          s_next.boot = kbl_pkg::KBL_BOOT_DONE;
          load = 1'b1;
        end else if (key_valid_i) begin
          if (key_code_i == kbl_pkg::CODE_CAPS_LOCK) begin
            // Release ignored; flag shows LED turned off
            code = {~caps_led_on_i, key_code_i};
            load = !key_up_i;
          end else begin
            code = {key_up_i, key_code_i};
            load = 1'b1;
          end
        end
        if (load) begin
          if (s_reg.sync == kbl_pkg::KBL_SYNC_OK) begin
            s_next.word = code;
            s_next.bitn = kbl_pkg::RESET_BITCNT;
          end
          s_next.shift = kbl_pkg::kbl_rotl(code);
          s_next.st = kbl_pkg::KBL_SETUP;
          s_next.cnt = 32'h0;
        end
      end
      kbl_pkg::KBL_SETUP: begin
        s_next.dat_oe = s_reg.shift[7]; // Low level carries a one
        s_next.cnt = s_reg.cnt + 32'h1;
        if (s_reg.cnt == 32'(kbl_pkg::SETUP_CYC - 1)) begin
          s_next.cnt = 32'h0;
          s_next.clk_oe = 1'b1;
          s_next.st = kbl_pkg::KBL_LOW;
        end
      end
      kbl_pkg::KBL_LOW: begin
        s_next.cnt = s_reg.cnt + 32'h1;
        if (s_reg.cnt == 32'(kbl_pkg::LOW_CYC - 1)) begin
          s_next.cnt = 32'h0;
          s_next.clk_oe = 1'b0;
          s_next.st = kbl_pkg::KBL_HOLD;
        end
      end
      kbl_pkg::KBL_HOLD: begin
        s_next.cnt = s_reg.cnt + 32'h1;
        if (s_reg.cnt == 32'(kbl_pkg::HOLD_CYC - 1)) begin
          s_next.cnt = 32'h0;
          if (s_reg.bitn == 4'h7) begin
            s_next.dat_oe = 1'b0;
            s_next.ack = 1'b0;
            s_next.st = kbl_pkg::KBL_WAIT_ACK;
          end else begin
            s_next.bitn = s_reg.bitn + 4'h1;
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.st = kbl_pkg::KBL_SETUP;
          end
        end
      end
      kbl_pkg::KBL_WAIT_ACK: begin
        s_next.cnt = s_reg.cnt + 32'h1;
        if (s_reg.ack && s_reg.d2) begin
          // Ack seen and line released again
          s_next.st = kbl_pkg::KBL_IDLE;
          s_next.cnt = 32'h0;
          s_next.ack = 1'b0;
          if (s_reg.sync == kbl_pkg::KBL_SYNC_LOST) begin
            s_next.word = kbl_pkg::CODE_LOST_SYNC; // Resend follows F9
            s_next.shift = kbl_pkg::kbl_rotl(kbl_pkg::CODE_LOST_SYNC);
            s_next.resend = 1'b1;
            s_next.bitn = kbl_pkg::RESET_BITCNT;
            s_next.st = kbl_pkg::KBL_SETUP;
            s_next.word = s_reg.word;
          end
          s_next.sync = kbl_pkg::KBL_SYNC_OK;
        end else if (s_reg.cnt == 32'(TMO_CYC - 1)) begin
          s_next.st = kbl_pkg::KBL_IDLE;
          s_next.cnt = 32'h0;
          if (s_reg.sync == kbl_pkg::KBL_SYNC_OK) begin
            s_next.sync = kbl_pkg::KBL_SYNC_LOST;
          end
        end
      end
      default: s_next.st = kbl_pkg::KBL_IDLE;
    endcase
  end

  // Single state register; power-up forces resync without lost-sync code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= kbl_pkg::KBL_IDLE;
      s_reg.sync <= kbl_pkg::KBL_SYNC_POWERUP;
      s_reg.boot <= kbl_pkg::KBL_BOOT_START;
      s_reg.d1 <= 1'b1;
      s_reg.d2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : kbl_keyboard

// ### sim/kbl_link_properties.sv
// Wire checker for the keyboard link: bit phases, ack width, resync wait.
// Assumes both link ends share clk_i and one interface joins them.
`timescale 1ns/100ps
module kbl_link_checker #(
  parameter int TMO_CYC = kbl_pkg::ACK_TMO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic kbd_clock_line_oe,
  input wire logic kbd_data_line_kbd_oe,
  input wire logic kbd_data_line_host_oe,
  input wire logic kbd_clock_line,
  input wire logic kbd_data_line
);
  localparam int LOW = kbl_pkg::LOW_CYC;
  localparam int HLD = kbl_pkg::HOLD_CYC;
  localparam int ACK = kbl_pkg::ACK_PULSE_CYC;
  typedef struct packed {
    logic [31:0] low;
    logic [31:0] hi;
    logic [31:0] dat;
    logic [31:0] ack;
    logic [3:0] edg;
    logic [2:0] oe;
  } kbl_chk_t;
  kbl_chk_t s_reg;
  kbl_chk_t s_next;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Phase run lengths; edge count clears when an ack ends
  always_comb begin
    s_next = s_reg;
    s_next.low = kbd_clock_line_oe ? s_reg.low + 32'h1 : 32'h0;
    s_next.hi = kbd_clock_line_oe ? 32'h0 : s_reg.hi + 32'h1;
    s_next.dat = (kbd_data_line_kbd_oe != s_reg.oe[1]) ? 32'h0 : s_reg.dat + 32'h1;
    s_next.ack = kbd_data_line_host_oe ? s_reg.ack + 32'h1 : 32'h0;
    if (s_reg.oe[2] && !kbd_clock_line_oe) begin
      s_next.edg = (s_reg.edg == 4'h8) ? 4'h1 : s_reg.edg + 4'h1;
    end
    if (s_reg.oe[0] && !kbd_data_line_host_oe) begin
      s_next.edg = 4'h0;
    end
    s_next.oe = {kbd_clock_line_oe, kbd_data_line_kbd_oe, kbd_data_line_host_oe};
  end
  // High run starts at the hold time so a word may begin right after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.hi <= 32'(HLD);
    end else begin
      s_reg <= s_next;
    end
  end
  property p_low_len;
    $fell(kbd_clock_line_oe) |-> s_reg.low >= LOW - 2 && s_reg.low <= LOW + 2;
  endproperty
  a_low_len: assert property (p_low_len) else $error("clock low width off");
  property p_setup;
    $rose(kbd_clock_line_oe) |-> s_reg.dat >= kbl_pkg::SETUP_CYC - 2;
  endproperty
  a_setup: assert property (p_setup) else $error("data setup too short");
  property p_hold;
    $changed(kbd_data_line_kbd_oe) |-> s_reg.hi >= HLD - 2;
  endproperty
  a_hold: assert property (p_hold) else $error("data hold too short");
  property p_stable_low;
    kbd_clock_line_oe |-> $stable(kbd_data_line_kbd_oe);
  endproperty
  a_stable_low: assert property (p_stable_low) else $error("data moved in clock low");
  property p_ack_len;
    $fell(kbd_data_line_host_oe) |-> s_reg.ack >= ACK - 2 && s_reg.ack <= ACK + 2;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack width off");
  property p_ack_eight;
    $rose(kbd_data_line_host_oe) |-> s_reg.edg == 4'h8;
  endproperty
  a_ack_eight: assert property (p_ack_eight) else $error("ack before eighth bit");
  property p_released;
    s_reg.edg == 4'h8 && s_reg.hi > HLD + 2 && s_reg.hi < HLD + 1000 |-> !kbd_data_line_kbd_oe;
  endproperty
  a_released: assert property (p_released) else $error("data kept after word");
  property p_resync;
    $rose(kbd_clock_line_oe) && s_reg.edg == 4'h8 |-> s_reg.hi >= TMO_CYC && s_reg.hi <= TMO_CYC + 5100;
  endproperty
  a_resync: assert property (p_resync) else $error("resync wait off");
endmodule : kbl_link_checker

// ### sim/keyboard_serial_link_bench.sv
// Bench: keyboard and host ends on one link; codes checked through a queue.
// Assumes 125 MHz clk_i; bit phases run full length, so words are slow.
`timescale 1ns/100ps
module keyboard_serial_link_bench;
  localparam int TMO = 20000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_rst = 1'b1;
  logic kv = 1'b0;
  logic ku = 1'b0;
  logic led = 1'b0;
  logic hv = 1'b0;
  logic [6:0] kc = 7'h00;
  logic [6:0] hc = 7'h00;
  logic key_ready, held_ready, synced, code_valid;
  logic [7:0] code, want;
  logic [7:0] sr = 8'h00;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'hEE2D;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  kbl_link_if kbl_link_if_i ();
  kbl_keyboard #(.TMO_CYC(TMO)) kbl_keyboard_i (.clk_i(clk_i), .rst_i(rst_i), .link(kbl_link_if_i.kbd),
    .key_valid_i(kv), .key_code_i(kc), .key_up_i(ku), .caps_led_on_i(led), .held_valid_i(hv), .held_code_i(hc),
    .held_last_i(1'b1), .key_ready_o(key_ready), .held_ready_o(held_ready), .synced_o(synced));
  kbl_host kbl_host_i (.clk_i(clk_i), .rst_i(host_rst), .link(kbl_link_if_i.host), .code_o(code),
    .code_valid_o(code_valid));
  kbl_link_checker #(.TMO_CYC(TMO)) kbl_link_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .kbd_clock_line_oe(kbl_link_if_i.kbd_clock_line_oe), .kbd_data_line_kbd_oe(kbl_link_if_i.kbd_data_line_kbd_oe),
    .kbd_data_line_host_oe(kbl_link_if_i.kbd_data_line_host_oe), .kbd_clock_line(kbl_link_if_i.kbd_clock_line),
    .kbd_data_line(kbl_link_if_i.kbd_data_line));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Request held until the edge that sees ready; note made at that take
  task automatic send_key(input logic [6:0] c, input logic up, input logic on, input logic [7:0] w, input logic s);
    @(posedge clk_i);
    #1;
    kc = c;
    ku = up;
    led = on;
    kv = 1'b1;
    // Ready looked at off the edge; the next edge is the take
    while (key_ready !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    if (s) exp_q.push_back(w);
    #1 kv = 1'b0;
  endtask : send_key
  // Own wire decode: first bit is bit 6, flag last, low level means one
  always @(posedge kbl_link_if_i.kbd_clock_line) sr <= {sr[6:0], ~kbl_link_if_i.kbd_data_line};
  // Result watcher and cycle ceiling
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1500000) begin
      n_mismatch++;
      finish_test();
    end
    if (code_valid === 1'b1) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      check(code, want);
      check({sr[0], sr[7:1]}, want);
    end
  end
  // Power-up stream, caps lock cases, random keys, then a missed ack
  initial begin
    exp_q.push_back(8'hFF);
    exp_q.push_back(kbl_pkg::CODE_STREAM_START);
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    host_rst = 1'b0;
    lfsr = next_rand(lfsr);
    hc = {1'b0, lfsr[5:0]};
    hv = 1'b1;
    while (held_ready !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    exp_q.push_back({1'b0, hc});
    exp_q.push_back(kbl_pkg::CODE_STREAM_END);
    #1 hv = 1'b0;
    send_key(7'h62, 1'b0, 1'b1, 8'h62, 1'b1);
    send_key(7'h62, 1'b1, 1'b0, 8'h00, 1'b0);
    send_key(7'h62, 1'b0, 1'b0, 8'hE2, 1'b1);
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      send_key({1'b0, lfsr[5:0]}, lfsr[7], 1'b0, {lfsr[7], 1'b0, lfsr[5:0]}, 1'b1);
    end
    // Host held in reset: word lost, resync ones, lost-sync code, resend
    while (exp_q.size() != 0) @(posedge clk_i);
    repeat (12000) @(posedge clk_i);
    #1 host_rst = 1'b1;
    exp_q.push_back(8'hFF);
    exp_q.push_back(kbl_pkg::CODE_LOST_SYNC);
    lfsr = next_rand(lfsr);
    send_key({1'b0, lfsr[5:0]}, 1'b0, 1'b0, {2'b00, lfsr[5:0]}, 1'b1);
    repeat (8) @(posedge kbl_link_if_i.kbd_clock_line);
    repeat (1000) @(posedge clk_i);
    #1 host_rst = 1'b0;
    while (exp_q.size() != 0) @(posedge clk_i);
    repeat (12000) @(posedge clk_i);
    check({6'h00, kbl_link_if_i.kbd_clock_line, kbl_link_if_i.kbd_data_line}, 8'h03);
    check({7'h00, synced}, 8'h01);
    finish_test();
  end
endmodule : keyboard_serial_link_bench
